// file: hdl/byte_alu_pkg.sv
// Purpose: Shared types and constants for the byte arithmetic logic unit.
// Assumes: One core clock; operands are bytes supplied by the decoder.
// Notes:   The result copy is the accumulator-like byte every op leaves.
package byte_alu_pkg;

  // Data widths and byte-level constants.
  localparam int          BYTE_W    = 8;
  localparam int          PROD_W    = 16;
  localparam int          MSB       = 7;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONES = 8'hff;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;

  // Reset values of the flags and result registers.
  localparam logic        CARRY_RST = 1'b0;
  localparam logic        OVF_RST   = 1'b0;
  localparam logic        ZERO_RST  = 1'b0;
  localparam logic [7:0]  DATA_RST  = 8'h00;

  // Operations carried out by the unit.
  typedef enum logic [3:0] {
    OP_DEC,    // Decrement.
    OP_DECC,   // Decrement with carry.
    OP_AND,    // Bitwise and.
    OP_OR,     // Bitwise or.
    OP_XOR,    // Bitwise exclusive or.
    OP_ADD,    // Addition.
    OP_ADDC,   // Addition with carry.
    OP_SUBD,   // Subtraction, operand minus register.
    OP_SUBDC,  // Same, with borrow.
    OP_SUBS,   // Subtraction, register minus operand.
    OP_SUBSC,  // Same, with borrow.
    OP_MUL     // Eight by eight multiply.
  } alu_op_t;

  // Operand forms of an instruction.
  typedef enum logic [2:0] {
    FORM_IMM,  // Register and immediate byte.
    FORM_R3,   // First register gets f(second, third).
    FORM_R2,   // First register gets f(first, second).
    FORM_R1,   // Single register, read and written.
    FORM_MEM   // Register and data memory byte.
  } alu_form_t;

  // One request from the decoder.
  typedef struct packed {
    alu_op_t    op;
    alu_form_t  form;
    logic [7:0] regFirst;
    logic [7:0] regSecond;
    logic [7:0] regThird;
    logic [7:0] immData;
    logic [7:0] memData;
  } alu_req_t;

  // Status flags.
  typedef struct packed {
    logic carry;
    logic ovf;
    logic zero;
  } alu_flags_t;

  // Bytes produced by one operation.
  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] copy;
  } alu_res_t;

endpackage : byte_alu_pkg

// file: hdl/byte_arith_logic_unit.sv
// Purpose: Byte arithmetic and logic execution unit of a small RISC core.
// Assumes: Request, operands and data_memory byte are valid in one cycle.
// Notes:   Results and flags appear one cycle after the request.
// Timing:
// The unit takes a request at the rising edge where opValid is high.
// The destination byte, the copy byte and the flags are registered there.
// They are visible from that edge on, so the answer comes one cycle later.
// destWrite_r is a one-cycle pulse that tells the register file to write.
// memAccess_r and indexUpdate_r pulse with it when the form is FORM_MEM.
// result_r holds its value until the next accepted request; flags_r also changes on flagLoad.
// Back-to-back requests every cycle are allowed.
// A chained operation uses the carry left in flags_r by the previous one.
//
// Flag preload:
// flagLoad writes flagLoadVal into flags_r in a cycle without a request.
// A request in the same cycle wins, and the preload is dropped.
// This lets the core restore a saved carry before a chained operation.
//
// Operand pairs (x is register side, y the other byte):
//   FORM_IMM - x is regFirst, y is immData.
//   FORM_R3  - x is regSecond, y is regThird.
//   FORM_R2  - x is regFirst, y is regSecond.
//   FORM_R1  - x and y are both regFirst.
//   FORM_MEM - x is regFirst, y is the data_memory byte.
//
// Decrement source:
//   FORM_R2 uses regSecond, FORM_MEM the data_memory byte.
//   Every other form uses regFirst.
//
// Carry conventions:
//   Addition leaves the carry out of bit seven in carry.
//   Subtraction leaves the inverted borrow, so carry low means underflow.
//   The borrow variants subtract one more when carry is low.
//   Decrement clears carry only when it wrapped from zero to all ones.
//
// Overflow:
//   Overflow is the signed two's complement overflow of the operation.
//   Logic operations leave carry and overflow alone.
//   Multiply leaves all three flags alone; their value is not defined.
//
// Hazards and limits:
//   Address and index arithmetic live outside; only pulses are given here.
//   Operand bytes must be valid in the same cycle as opValid.
//   Illegal operation codes keep result, carry and overflow; illegal form codes act as FORM_IMM.
`timescale 1ns/1ns
`default_nettype none

module byte_arith_logic_unit (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Request from the decoder.
  input  wire logic                     opValid,
  input  wire byte_alu_pkg::alu_req_t   opReq,
  // Flag preload from the core.
  input  wire logic                     flagLoad,
  input  wire byte_alu_pkg::alu_flags_t flagLoadVal,
  // Result towards the register file.
  output var  logic                     destWrite_r,
  output var  byte_alu_pkg::alu_res_t   result_r,
  // Flags.
  output var  byte_alu_pkg::alu_flags_t flags_r,
  // Memory operand side effects.
  output var  logic                     memAccess_r,
  output var  logic                     indexUpdate_r
);
  import byte_alu_pkg::*;

  // Next values of all registers.
  logic       destWrite_nxt;
  alu_res_t   result_nxt;
  alu_flags_t flags_nxt;
  logic       memAccess_nxt;
  logic       indexUpdate_nxt;

  // Operand pair, with x the register-side byte and y the other one.
  logic [7:0] opX;
  logic [7:0] opY;
  logic [7:0] decSrc;

  // Minuend and subtrahend of subtraction.
  logic [7:0] subP;
  logic [7:0] subQ;

  // Intermediate arithmetic values; sum and difference are one bit wider than a byte.
  logic [8:0] sumWide;
  logic [8:0] diffWide;
  logic [7:0] decRes;
  logic [PROD_W-1:0] product;
  logic       carryIn;
  logic       borrowIn;
  logic       decBorrow;
  logic       decOvf;

  // Select the operand pair from the form of the instruction.
  always_comb begin
    opX    = opReq.regFirst;
    opY    = opReq.immData;
    decSrc = opReq.regFirst;
    unique case (opReq.form)
      FORM_IMM: begin
        opX = opReq.regFirst;
        opY = opReq.immData;
      end
      FORM_R3: begin
        opX = opReq.regSecond;
        opY = opReq.regThird;
      end
      FORM_R2: begin
        opX    = opReq.regFirst;
        opY    = opReq.regSecond;
        decSrc = opReq.regSecond;
      end
      FORM_R1: begin
        opX    = opReq.regFirst;
        opY    = opReq.regFirst;
        decSrc = opReq.regFirst;
      end
      FORM_MEM: begin
        opX    = opReq.regFirst;
        opY    = opReq.memData;
        decSrc = opReq.memData;
      end
      default: begin
        opX    = opReq.regFirst;
        opY    = opReq.immData;
        decSrc = opReq.regFirst;
      end
    endcase
  end

  // Pick minuend and subtrahend; the three-register form swaps the order.
  always_comb begin
    subP = opY;
    subQ = opX;
    unique case (opReq.op)
      OP_SUBD, OP_SUBDC: begin
        if (opReq.form == FORM_R3) begin
          subP = opX;
          subQ = opY;
        end else begin
          subP = opY;
          subQ = opX;
        end
      end
      OP_SUBS, OP_SUBSC: begin
        if (opReq.form == FORM_R3) begin
          subP = opY;
          subQ = opX;
        end else begin
          subP = opX;
          subQ = opY;
        end
      end
      default: begin
        subP = opY;
        subQ = opX;
      end
    endcase
  end

  // Shared adder, subtractor, decrementer and multiplier.
  always_comb begin
    carryIn   = (opReq.op == OP_ADDC) ? flags_r.carry : 1'b0;
    // A cleared carry is a pending borrow in the borrow variants.
    borrowIn  = ((opReq.op == OP_SUBDC) || (opReq.op == OP_SUBSC))
                ? ~flags_r.carry : 1'b0;
    decBorrow = (opReq.op == OP_DECC) ? ~flags_r.carry : 1'b1;
    sumWide   = {1'b0, opX} + {1'b0, opY} + {8'h00, carryIn};
    diffWide  = {1'b0, subP} - {1'b0, subQ} - {8'h00, borrowIn};
    decRes    = decSrc - {7'h00, decBorrow};
    product   = {8'h00, opX} * {8'h00, opY};
    // Signed overflow of a decrement: a negative source turned positive.
    decOvf    = decBorrow & decSrc[MSB] & ~decRes[MSB];
  end

  // Compute the result bytes and flags of the current request.
  always_comb begin
    destWrite_nxt   = 1'b0;
    result_nxt      = result_r;
    flags_nxt       = flags_r;
    memAccess_nxt   = 1'b0;
    indexUpdate_nxt = 1'b0;
    if (opValid) begin
      destWrite_nxt   = 1'b1;
      // Memory forms fetch the byte and run the index step at once.
      memAccess_nxt   = (opReq.form == FORM_MEM);
      indexUpdate_nxt = (opReq.form == FORM_MEM);
      unique case (opReq.op)
        OP_DEC, OP_DECC: begin
          result_nxt.dest = decRes;
          result_nxt.copy = decRes;
          // Carry drops only when the decrement wrapped past zero.
          flags_nxt.carry = ~((decRes == BYTE_ONES) && decBorrow);
          flags_nxt.ovf   = decOvf;
        end
        OP_AND: begin
          result_nxt.dest = opX & opY;
          result_nxt.copy = opX & opY;
        end
        OP_OR: begin
          result_nxt.dest = opX | opY;
          result_nxt.copy = opX | opY;
        end
        OP_XOR: begin
          result_nxt.dest = opX ^ opY;
          result_nxt.copy = opX ^ opY;
        end
        OP_ADD, OP_ADDC: begin
          result_nxt.dest = sumWide[BYTE_W-1:0];
          result_nxt.copy = sumWide[BYTE_W-1:0];
          flags_nxt.carry = sumWide[BYTE_W];
          // Signed overflow: like signs in, other sign out.
          flags_nxt.ovf   = (opX[MSB] == opY[MSB])
                            && (sumWide[MSB] != opX[MSB]);
        end
        OP_SUBD, OP_SUBDC, OP_SUBS, OP_SUBSC: begin
          result_nxt.dest = diffWide[BYTE_W-1:0];
          result_nxt.copy = diffWide[BYTE_W-1:0];
          // Carry is the inverted borrow out of bit seven.
          flags_nxt.carry = ~diffWide[BYTE_W];
          flags_nxt.ovf   = (subP[MSB] != subQ[MSB])
                            && (diffWide[MSB] != subP[MSB]);
        end
        OP_MUL: begin
          result_nxt.dest = product[PROD_W-1:BYTE_W];
          result_nxt.copy = product[BYTE_W-1:0];
        end
        default: begin
          // An illegal code keeps the result bytes, carry and overflow; destWrite_r still pulses.
          result_nxt = result_r;
        end
      endcase
      // Every op but multiply refreshes the zero flag from the copy.
      if (opReq.op != OP_MUL) begin
        flags_nxt.zero = (result_nxt.copy == BYTE_ZERO);
      end
    end else if (flagLoad) begin
      flags_nxt = flagLoadVal;
    end
  end

  // Register the outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      destWrite_r   <= 1'b0;
      result_r      <= '{dest: DATA_RST, copy: DATA_RST};
      flags_r       <= '{carry: CARRY_RST, ovf: OVF_RST, zero: ZERO_RST};
      memAccess_r   <= 1'b0;
      indexUpdate_r <= 1'b0;
    end else begin
      destWrite_r   <= destWrite_nxt;
      result_r      <= result_nxt;
      flags_r       <= flags_nxt;
      memAccess_r   <= memAccess_nxt;
      indexUpdate_r <= indexUpdate_nxt;
    end
  end

endmodule : byte_arith_logic_unit

`default_nettype wire

// file: sim/decoder_model.sv
// Purpose: Decoder side model that issues requests and flag presets.
// Assumes: Inputs of the unit change only at the falling clock edge.
// Notes:   Operands are scrambled while no request is pending.
`timescale 1ns/1ns
`default_nettype none
module decoder_model (
  // Clock.
  input  wire logic                     clk,
  // Requests and flag preset toward the unit.
  output var  logic                     opValid,
  output var  byte_alu_pkg::alu_req_t   opReq,
  output var  logic                     flagLoad,
  output var  byte_alu_pkg::alu_flags_t flagLoadVal
);
  import byte_alu_pkg::*;
  // Idle levels at time zero.
  initial begin
    opValid = 1'b0;
    opReq = '0;
    flagLoad = 1'b0;
    flagLoadVal = '0;
  end
  // One request held for one cycle; operands v = first,second,third,imm,mem.
  task automatic send(alu_op_t o, alu_form_t f, logic [39:0] v);
    @(negedge clk);
    opValid <= 1'b1;
    opReq <= {o, f, v};
    @(negedge clk);
    opValid <= 1'b0;
    opReq <= ~opReq;
  endtask : send
  // Preset the carry flag with no request in that cycle.
  task automatic preset(logic c);
    @(negedge clk);
    flagLoad <= 1'b1;
    flagLoadVal <= {c, 2'h0};
    @(negedge clk);
    flagLoad <= 1'b0;
  endtask : preset
endmodule : decoder_model
`default_nettype wire

// file: sim/alu_checker_sva.sv
// Purpose: Timing and value checks at the ports of the byte unit.
// Assumes: Results show one clock after the accepted request.
// Notes:   Attached to every instance of the unit by bind.
`timescale 1ns/1ns
`default_nettype none
module alu_checker (
  // Clock and reset.
  input wire logic                     clk,
  input wire logic                     rst_n,
  // Unit inputs.
  input wire logic                     opValid,
  input wire byte_alu_pkg::alu_req_t   opReq,
  input wire logic                     flagLoad,
  input wire byte_alu_pkg::alu_flags_t flagLoadVal,
  // Unit outputs.
  input wire logic                     destWrite_r,
  input wire byte_alu_pkg::alu_res_t   result_r,
  input wire byte_alu_pkg::alu_flags_t flags_r,
  input wire logic                     memAccess_r,
  input wire logic                     indexUpdate_r
);
  import byte_alu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Accepted requests by operand form.
  sequence s_mem; opValid && opReq.form == FORM_MEM; endsequence
  sequence s_reg; opValid && opReq.form != FORM_MEM; endsequence
  property p_answer; opValid |=> destWrite_r; endproperty
  property p_quiet; !opValid |=> !destWrite_r && !memAccess_r; endproperty
  property p_memPulse; s_mem |=> memAccess_r && indexUpdate_r; endproperty
  property p_noMem; s_reg |=> !memAccess_r && !indexUpdate_r; endproperty
  property p_andR3;
    s_reg ##0 opReq.op == OP_AND && opReq.form == FORM_R3 |=>
      result_r.copy == ($past(opReq.regSecond) & $past(opReq.regThird));
  endproperty
  property p_logicFlags;
    opValid && opReq.op inside {OP_AND, OP_OR, OP_XOR} |=>
      $stable(flags_r.carry) && $stable(flags_r.ovf);
  endproperty
  property p_zero;
    opValid && opReq.op != OP_MUL |=> flags_r.zero == (result_r.copy == 8'h00);
  endproperty
  property p_addR3;
    opValid && opReq.op == OP_ADD && opReq.form == FORM_R3 |=>
      {flags_r.carry, result_r.copy} ==
      {1'b0, $past(opReq.regSecond)} + {1'b0, $past(opReq.regThird)};
  endproperty
  property p_mulImm;
    opValid && opReq.op == OP_MUL && opReq.form == FORM_IMM |=>
      result_r == $past(opReq.regFirst) * $past(opReq.immData);
  endproperty
  a_answer: assert property (p_answer) else $error("no write pulse");
  a_quiet: assert property (p_quiet) else $error("stray pulse");
  a_memPulse: assert property (p_memPulse) else $error("no mem pulse");
  a_noMem: assert property (p_noMem) else $error("mem pulse on reg op");
  a_andR3: assert property (p_andR3) else $error("and result wrong");
  a_logicFlags: assert property (p_logicFlags) else $error("c/v moved");
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_addR3: assert property (p_addR3) else $error("sum or carry wrong");
  a_mulImm: assert property (p_mulImm) else $error("product wrong");
endmodule : alu_checker
bind byte_arith_logic_unit alu_checker u_chk (.clk(clk), .rst_n(rst_n),
  .opValid(opValid), .opReq(opReq), .flagLoad(flagLoad),
  .flagLoadVal(flagLoadVal), .destWrite_r(destWrite_r), .result_r(result_r),
  .flags_r(flags_r), .memAccess_r(memAccess_r), .indexUpdate_r(indexUpdate_r));
`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench running every operation of the byte unit.
// Assumes: Expected bytes and flags worked out by hand per operation.
// Notes:   Carry is chained from one operation to the next.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import byte_alu_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       opValid, flagLoad, destWrite, memAcc, idxUpd;
  alu_req_t   opReq;
  alu_flags_t flagLoadVal, flags;
  alu_res_t   result;
  int         err_count = 0;
  int         comparisons = 0;
  // Core clock of 100 MHz.
  always #5 clk = ~clk;
  decoder_model dec (.clk(clk), .opValid(opValid), .opReq(opReq),
    .flagLoad(flagLoad), .flagLoadVal(flagLoadVal));
  byte_arith_logic_unit DUT (.clk(clk), .rst_n(rst_n), .opValid(opValid),
    .opReq(opReq), .flagLoad(flagLoad), .flagLoadVal(flagLoadVal),
    .destWrite_r(destWrite), .result_r(result), .flags_r(flags),
    .memAccess_r(memAcc), .indexUpdate_r(idxUpd));
  // Compare one value and count it.
  function automatic void chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endfunction : chk
  // Issue one operation, then check dest/copy and {carry, zero}.
  task automatic t(alu_op_t o, alu_form_t f, logic [39:0] v, logic [15:0] e,
                   logic [1:0] cz);
    dec.send(o, f, v);
    chk("write", 16'h0001, {15'h0, destWrite});
    chk("result", e, result);
    chk("carry_zero", {14'h0, cz}, {14'h0, flags.carry, flags.zero});
    chk("mem_index", {14'h0, {2{f == FORM_MEM}}}, {14'h0, memAcc, idxUpd});
    $display("test %s done", o.name());
  endtask : t
  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the expected 62 cycles.
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  // Main sequence; operands are first,second,third,imm,mem.
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    t(OP_DEC, FORM_R1, 40'h00_00_00_00_00, 16'hffff, 2'h0);
    t(OP_DEC, FORM_MEM, 40'h55_00_00_00_01, 16'h0000, 2'h3);
    dec.preset(1'b0);
    t(OP_DECC, FORM_R1, 40'h00_00_00_00_00, 16'hffff, 2'h0);
    dec.preset(1'b1);
    t(OP_DECC, FORM_R1, 40'h00_00_00_00_00, 16'h0000, 2'h3);
    t(OP_AND, FORM_IMM, 40'hf0_00_00_3c_00, 16'h3030, 2'h2);
    t(OP_AND, FORM_R3, 40'h00_0f_f0_00_00, 16'h0000, 2'h3);
    t(OP_OR, FORM_R3, 40'h00_05_0a_00_00, 16'h0f0f, 2'h2);
    t(OP_OR, FORM_MEM, 40'h80_00_00_00_01, 16'h8181, 2'h2);
    t(OP_XOR, FORM_R3, 40'h00_ff_0f_00_00, 16'hf0f0, 2'h2);
    t(OP_ADD, FORM_R3, 40'h00_ff_01_00_00, 16'h0000, 2'h3);
    t(OP_ADDC, FORM_R2, 40'h10_20_00_00_00, 16'h3131, 2'h0);
    t(OP_ADD, FORM_MEM, 40'hf0_00_00_00_20, 16'h1010, 2'h2);
    t(OP_SUBD, FORM_IMM, 40'h06_00_00_05_00, 16'hffff, 2'h0);
    t(OP_SUBD, FORM_R3, 40'h00_09_03_00_00, 16'h0606, 2'h2);
    t(OP_SUBD, FORM_R2, 40'h03_09_00_00_00, 16'h0606, 2'h2);
    t(OP_SUBD, FORM_MEM, 40'h10_00_00_00_10, 16'h0000, 2'h3);
    dec.preset(1'b0);
    t(OP_SUBDC, FORM_R3, 40'h00_10_0f_00_00, 16'h0000, 2'h3);
    t(OP_SUBS, FORM_IMM, 40'h02_00_00_03_00, 16'hffff, 2'h0);
    t(OP_SUBS, FORM_R3, 40'h00_01_05_00_00, 16'h0404, 2'h2);
    t(OP_SUBS, FORM_R2, 40'h05_06_00_00_00, 16'hffff, 2'h0);
    t(OP_SUBSC, FORM_R3, 40'h00_01_01_00_00, 16'hffff, 2'h0);
    t(OP_MUL, FORM_IMM, 40'h10_00_00_20_00, 16'h0200, 2'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
